// ==== hw/lcdw_front.sv ====
// Purpose: Write-only two-wire serial receiver of a segment LCD driver.
// Assumes: SCL and SDA are sampled by clk_i, far faster than the bus.
// Notes:   Command decoding lives outside; it loads pointer and subaddress.
//
// Contract
// - Answer only addresses 0111000 and 0111001.
// - Address bit 1 must equal strap.
// - Read requests get no response.
// - Matching devices acknowledge address together.
// - Non-matching device ignores until start/stop.
// - Control select routes next byte: command/display.
// - Continue flag one expects another control.
// - Selected devices acknowledge control, command bytes.
// - Display byte written, pointer advances; subaddress on wrap.
// - Display ack only on subaddress match.
// - Stop or repeated start restarts recognition.
// - Never transmit; only ack pulls low.
// - Subaddress is two straps, binary coded.

`timescale 1ns/1ps

module lcdw_front
    import lcdw_pkg::*;
#(
    parameter int DEPTH = RAM_DEPTH,
    parameter int AW    = RAM_AW
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          scl_i,
    input  wire logic          sda_i,
    output logic               sda_o,
    output logic               sda_oe_b_o,
    input  wire logic          addr_select_strap_i,
    input  wire logic          hw_subaddr_bit_low_i,
    input  wire logic          hw_subaddr_bit_high_i,
    input  wire logic          ptr_load_i,
    input  wire logic [AW-1:0] ptr_value_i,
    input  wire logic          sub_load_i,
    input  wire logic [1:0]    sub_value_i,
    input  wire logic [AW-1:0] disp_rd_addr_i,
    output logic [DATA_W-1:0]  disp_rd_data_o,
    output logic [DATA_W-1:0]  cmd_data_o,
    output logic               cmd_valid_o
);

    // ------------------------------------------------------------------
    // State.
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              scl_s1;    // Clock line, first sync stage.
        logic              scl_s2;    // Clock line, second sync stage.
        logic              scl_d;     // Clock line, edge history.
        logic              sda_s1;    // Data line, first sync stage.
        logic              sda_s2;    // Data line, second sync stage.
        logic              sda_d;     // Data line, edge history.
        logic [2:0]        strap_s1;  // Straps, first sync stage.
        logic [2:0]        strap_s2;  // Straps: high, low, select.
        lcdw_state_type    state;     // Protocol state.
        logic [3:0]        cnt;       // Bits received in this byte.
        logic              in_ack;    // Inside the ninth clock.
        logic [DATA_W-1:0] shreg;     // Incoming byte.
        logic              cont;      // Latched continue flag.
        logic              sel;       // Latched register select.
        logic [AW-1:0]     ptr;       // Display data pointer.
        logic [1:0]        sub;       // Selected hardware subaddress.
        logic              sda_out;   // Data driven when enabled.
        logic              sda_oe_b;  // Low while pulling SDA.
        logic [DATA_W-1:0] cmd_data;  // Last command byte.
        logic              cmd_valid; // One-cycle command strobe.
        logic              wr_en;     // Display write strobe.
        logic [AW-1:0]     wr_addr;   // Display write address.
        logic [DATA_W-1:0] wr_data;   // Display write byte.
    } lcdw_regs_type;

    // Idle bus is high, so the line stages reset high to avoid a
    // false start right after reset.
    localparam lcdw_regs_type RST = '{
        scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1,
        sda_s1: 1'b1, sda_s2: 1'b1, sda_d: 1'b1,
        state: ST_IDLE, sda_oe_b: 1'b1, sub: SUB_RESET,
        default: '0
    };

    lcdw_regs_type r;     // Registered state.
    lcdw_regs_type n;     // Next state.
    logic scl_rise;       // Clock rose.
    logic scl_fall;       // Clock fell.
    logic start_det;      // Start or repeated start seen.
    logic stop_det;       // Stop seen.
    logic byte_end;       // Eighth bit done, ack slot opens.
    logic addr_hit;       // Address byte selects this device.
    logic sub_hit;        // Straps equal the selected subaddress.

    // ------------------------------------------------------------------
    // Pointer arithmetic.
    // ------------------------------------------------------------------
    // Next display address; wraps so cascaded parts stay in step.
    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        if (int'(p) >= DEPTH - 1) begin
            return '0;
        end
        return AW'(p + 1'b1);
    endfunction

    // ------------------------------------------------------------------
    // Line events, from second sync stage and its history only.
    // ------------------------------------------------------------------
    always_comb begin
        scl_rise  = r.scl_s2 && !r.scl_d;
        scl_fall  = !r.scl_s2 && r.scl_d;
        start_det = r.scl_s2 && r.scl_d && r.sda_d && !r.sda_s2;
        stop_det  = r.scl_s2 && r.scl_d && !r.sda_d && r.sda_s2;
        byte_end  = scl_fall && (r.cnt == BIT_CNT_ACK) && !r.in_ack;
        addr_hit  = (r.shreg[7:2] == ADDR_BASE) &&
                    (r.shreg[ADDR_SEL_BIT] == r.strap_s2[0]) &&
                    (r.shreg[ADDR_RW_BIT] == DIR_WRITE);
        sub_hit   = (r.sub == r.strap_s2[2:1]);
    end

    // ------------------------------------------------------------------
    // Next state.
    // ------------------------------------------------------------------
    // Bits shift in on SCL rising; byte effects and the ack drive start
    // on the falling edge after the eighth bit, so SDA only ever moves
    // while SCL is low.
    always_comb begin
        n = r;
        n.scl_s1    = scl_i;
        n.scl_s2    = r.scl_s1;
        n.scl_d     = r.scl_s2;
        n.sda_s1    = sda_i;
        n.sda_s2    = r.sda_s1;
        n.sda_d     = r.sda_s2;
        n.strap_s1  = {hw_subaddr_bit_high_i, hw_subaddr_bit_low_i,
                       addr_select_strap_i};
        n.strap_s2  = r.strap_s1;
        n.cmd_valid = 1'b0;
        n.wr_en     = 1'b0;
        n.sda_out   = 1'b0;
        // Loads from the command layer; a display byte in the same cycle
        // overrides the pointer load below, and the subaddress load on a wrap.
        if (ptr_load_i) begin
            n.ptr = ptr_value_i;
        end
        if (sub_load_i) begin
            n.sub = sub_value_i;
        end
        if (start_det) begin
            // A start always reopens address recognition.
            n.state    = ST_ADDR;
            n.cnt      = '0;
            n.in_ack   = 1'b0;
            n.sda_oe_b = 1'b1;
        end else if (stop_det) begin
            n.state    = ST_IDLE;
            n.cnt      = '0;
            n.in_ack   = 1'b0;
            n.sda_oe_b = 1'b1;
        end else if (r.state != ST_IDLE) begin
            if (scl_rise && !r.in_ack && (r.cnt != BIT_CNT_ACK)) begin
                n.shreg = {r.shreg[DATA_W-2:0], r.sda_s2};
                n.cnt   = 4'(r.cnt + 4'h1);
            end else if (byte_end) begin
                n.in_ack = 1'b1;
                case (r.state)
                    ST_ADDR: begin
                        if (addr_hit) begin
                            n.sda_oe_b = 1'b0;
                            n.state    = ST_CTRL;
                        end else begin
                            n.state = ST_IGNR;
                        end
                    end
                    ST_CTRL: begin
                        n.sda_oe_b = 1'b0;
                        n.cont     = r.shreg[CTRL_CONT_BIT];
                        n.sel      = r.shreg[CTRL_SEL_BIT];
                        n.state    = ST_DATA;
                    end
                    ST_DATA: begin
                        if (r.sel == SEL_COMMAND) begin
                            n.sda_oe_b  = 1'b0;
                            n.cmd_data  = r.shreg;
                            n.cmd_valid = 1'b1;
                        end else begin
                            // Only the addressed subaddress stores and
                            // answers, but every part keeps counting.
                            if (sub_hit) begin
                                n.sda_oe_b = 1'b0;
                                n.wr_en    = 1'b1;
                            end
                            n.wr_addr = r.ptr;
                            n.wr_data = r.shreg;
                            n.ptr     = ptr_inc(r.ptr);
                            if (int'(r.ptr) >= DEPTH - 1) begin
                                n.sub = 2'(r.sub + 2'h1);
                            end
                        end
                        n.state = r.cont ? ST_CTRL : ST_DATA;
                    end
                    default: begin
                        n.state = r.state;
                    end
                endcase
            end else if (scl_fall && r.in_ack) begin
                // End of the ninth clock: let go of the line.
                n.in_ack   = 1'b0;
                n.sda_oe_b = 1'b1;
                n.cnt      = '0;
            end
        end
    end

    // Single state register.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= RST;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs and display store.
    // ------------------------------------------------------------------
    assign sda_o       = r.sda_out;
    assign sda_oe_b_o  = r.sda_oe_b;
    assign cmd_data_o  = r.cmd_data;
    assign cmd_valid_o = r.cmd_valid;

    lcdw_ram #(.DW(DATA_W), .DEPTH(DEPTH), .AW(AW)) u_ram (
        .clk_i     (clk_i),
        .rst_b_i   (rst_b_i),
        .wr_en_i   (r.wr_en),
        .wr_addr_i (r.wr_addr),
        .wr_data_i (r.wr_data),
        .rd_addr_i (disp_rd_addr_i),
        .rd_data_o (disp_rd_data_o)
    );

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    wire in_addr = byte_end && (r.state == ST_ADDR);
    wire in_data = byte_end && (r.state == ST_DATA);

    AST_NO_DATA: assert property (sda_o == 1'b0)
        else $error("SDA output value not low.");
    AST_ACK_SLOT: assert property (!sda_oe_b_o |-> r.in_ack)
        else $error("SDA driven outside the ack clock.");
    AST_RELEASE: assert property (scl_fall && r.in_ack &&
        !start_det && !stop_det |=> sda_oe_b_o && r.cnt == 4'h0)
        else $error("SDA not released after ninth clock.");
    AST_BAD_ADDR: assert property (in_addr &&
        (r.shreg[7:2] != ADDR_BASE || r.shreg[ADDR_RW_BIT])
        |=> sda_oe_b_o && r.state == ST_IGNR)
        else $error("Foreign or read address answered.");
    AST_STRAP: assert property (in_addr &&
        r.shreg[ADDR_SEL_BIT] != r.strap_s2[0] |=> r.state == ST_IGNR)
        else $error("Strap mismatch not ignored.");
    AST_ADDR_ACK: assert property (in_addr && addr_hit |=>
        !sda_oe_b_o && r.state == ST_CTRL)
        else $error("Matching address not acknowledged.");
    AST_IGNORE: assert property (r.state == ST_IGNR &&
        !start_det && !stop_det |=> r.state == ST_IGNR)
        else $error("Ignored transfer resumed early.");
    AST_CTRL: assert property (byte_end && r.state == ST_CTRL |=>
        !sda_oe_b_o && r.sel == $past(r.shreg[CTRL_SEL_BIT])
        && r.cont == $past(r.shreg[CTRL_CONT_BIT]))
        else $error("Control byte mishandled.");
    AST_CMD: assert property (in_data && !r.sel |=> cmd_valid_o
        && cmd_data_o == $past(r.shreg) ##1 !cmd_valid_o)
        else $error("Command byte not delivered once.");
    AST_DISP_ACK: assert property (in_data && r.sel |=>
        sda_oe_b_o == !$past(sub_hit))
        else $error("Display ack disagrees with subaddress.");
    AST_PTR: assert property (in_data && r.sel |=>
        r.ptr == ptr_inc($past(r.ptr)))
        else $error("Display pointer did not advance.");
    AST_CONT: assert property (in_data |=>
        r.state == ($past(r.cont) ? ST_CTRL : ST_DATA))
        else $error("Continue flag not honoured.");
    AST_RESTART: assert property (start_det |=> r.state == ST_ADDR
        && sda_oe_b_o)
        else $error("Start did not reopen addressing.");

    COV_ADDR: cover property (in_addr && addr_hit);
    COV_DISP: cover property (r.wr_en);
    COV_CMD:  cover property (cmd_valid_o);
    COV_RSTART: cover property (r.state == ST_DATA && start_det);

endmodule

// ==== inc/lcdw_pkg.sv ====
// Purpose: Shared constants and types of the LCD write front end.
// Assumes: Bit positions follow the serial byte order, MSB first.
// Notes:   Every number used by the design lives here once.

package lcdw_pkg;

    // ------------------------------------------------------------------
    // Address byte layout.
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_BASE    = 6'h1c; // Upper six address bits.
    localparam int         ADDR_RW_BIT  = 0;     // Direction bit position.
    localparam int         ADDR_SEL_BIT = 1;     // Strap compare position.
    localparam logic       DIR_WRITE    = 1'b0;  // Only writes are served.

    // ------------------------------------------------------------------
    // Control byte layout.
    // ------------------------------------------------------------------
    localparam int   CTRL_CONT_BIT = 7;          // Continue flag position.
    localparam int   CTRL_SEL_BIT  = 6;          // Register select position.
    localparam logic SEL_COMMAND   = 1'b0;       // Byte goes to commands.

    // ------------------------------------------------------------------
    // Byte framing and reset values.
    // ------------------------------------------------------------------
    localparam logic [3:0] BIT_CNT_ACK = 4'h8;   // Bits before the ack slot.
    localparam logic [1:0] SUB_RESET   = 2'h0;   // Selected subaddress.
    localparam int         RAM_DEPTH   = 40;     // Display bytes per device.
    localparam int         RAM_AW      = 6;      // Display address width.
    localparam int         DATA_W      = 8;      // Serial byte width.

    // ------------------------------------------------------------------
    // Protocol states, one-hot.
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,  // Bus free or after a stop.
        ST_ADDR = 5'h02,  // Receiving the address byte.
        ST_CTRL = 5'h04,  // Receiving a control byte.
        ST_DATA = 5'h08,  // Receiving command or display bytes.
        ST_IGNR = 5'h10   // Not addressed; wait for start or stop.
    } lcdw_state_type;

endpackage

// ==== hw/lcdw_ram.sv ====
// Purpose: Display byte store with one write and one registered read port.
// Assumes: Both ports run on the same clock.
// Notes:   The array itself has no reset; contents are undefined at power.

`timescale 1ns/1ps

module lcdw_ram
    import lcdw_pkg::*;
#(
    parameter int DW    = DATA_W,
    parameter int DEPTH = RAM_DEPTH,
    parameter int AW    = RAM_AW
) (
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          wr_en_i,
    input  wire logic [AW-1:0] wr_addr_i,
    input  wire logic [DW-1:0] wr_data_i,
    input  wire logic [AW-1:0] rd_addr_i,
    output logic      [DW-1:0] rd_data_o
);

    logic [DW-1:0] mem [DEPTH];  // Storage cells.

    // Write port; addresses past the end are dropped.
    always_ff @(posedge clk_i) begin
        if (wr_en_i && (int'(wr_addr_i) < DEPTH)) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    // Registered read so the output comes from a flip-flop.
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_data_o <= '0;
        end else if (int'(rd_addr_i) < DEPTH) begin
            rd_data_o <= mem[rd_addr_i];
        end else begin
            rd_data_o <= '0;
        end
    end

endmodule

// ==== bench/lcdw_bus_master.sv ====
// Purpose: Behavioural two-wire bus master that feeds the LCD front end.
// Assumes: SDA is open drain with a pull-up; sda_o of 1 releases the line.
// Notes:   SCL runs only inside frames, 125 ns a bit, and idles high.

`timescale 1ns/1ps

module lcdw_bus_master (
    input  wire logic sda_bus_i,
    output logic      scl_o,
    output logic      sda_o
);

    // Both lines rest high while the bus is free.
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    // ------------------------------------------------------------------
    // Frame conditions.
    // ------------------------------------------------------------------
    // Start or repeated start: SDA falls while SCL is high.
    task automatic start_cond();
        #45 sda_o = 1'b1;
        #18 scl_o = 1'b1;
        #31 sda_o = 1'b0;
        #31 scl_o = 1'b0;
    endtask

    // Stop: SDA rises while SCL is high; the clock then stands still.
    task automatic stop_cond();
        #45 sda_o = 1'b0;
        #18 scl_o = 1'b1;
        #31 sda_o = 1'b1;
        #31;
    endtask

    // One byte MSB first, then a released ninth clock for the ack.
    // SDA moves 45 ns after SCL falls, well past the receiver's delay.
    task automatic send_byte(input  logic [7:0] b,
                             output logic       ack,
                             output logic       clean);
        clean = 1'b1;
        for (int i = 7; i >= 0; i--) begin
            #45 sda_o = b[i];
            #18 scl_o = 1'b1;
            #31;
            if (sda_bus_i !== b[i]) begin
                clean = 1'b0;
            end
            #31 scl_o = 1'b0;
        end
        #45 sda_o = 1'b1;
        #18 scl_o = 1'b1;
        #31 ack = (sda_bus_i === 1'b0);
        #31 scl_o = 1'b0;
    endtask

endmodule

// ==== bench/lcdw_front_tb.sv ====
// Purpose: Self-checking bench of the LCD write front end.
// Assumes: The bus master model runs the link; SDA has a pull-up.
// Notes:   A scoreboard of pointer, subaddress and store predicts results.

`timescale 1ns/1ps

module lcdw_front_tb
    import lcdw_pkg::*;
;
    localparam logic [7:0] BAD [5] = '{8'h72, 8'h71, 8'h73, 8'h50, 8'hf0};

    logic       clk_i;
    logic       rst_b_i;
    logic       scl, sda_m, sda_bus, sda_d, oe_b;
    logic       sa, hlo, hhi, pld, sld;
    logic [5:0] pval, rda;
    logic [1:0] sval, sub;
    logic [7:0] rdd, cmdd;
    logic       cmdv;
    logic [7:0] exp_ram [RAM_DEPTH];
    bit         wr_m [RAM_DEPTH];
    logic [7:0] cq [$];
    int         ptr, n_errors, n_checks, seed;

    // Wired-AND of the pull-up, the master and the device's pull-down.
    assign sda_bus = sda_m & (oe_b | sda_d);

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    lcdw_bus_master m (.sda_bus_i(sda_bus), .scl_o(scl), .sda_o(sda_m));

    lcdw_front dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda_bus),
        .sda_o(sda_d), .sda_oe_b_o(oe_b), .addr_select_strap_i(sa),
        .hw_subaddr_bit_low_i(hlo), .hw_subaddr_bit_high_i(hhi),
        .ptr_load_i(pld), .ptr_value_i(pval), .sub_load_i(sld),
        .sub_value_i(sval), .disp_rd_addr_i(rda), .disp_rd_data_o(rdd),
        .cmd_data_o(cmdd), .cmd_valid_o(cmdv));

    // Every command pulse is queued so that stray pulses are seen too.
    always @(posedge clk_i) begin
        if (cmdv === 1'b1) begin
            cq.push_back(cmdd);
        end
    end

    // ------------------------------------------------------------------
    // Expectation helpers and drivers.
    // ------------------------------------------------------------------
    function automatic logic [7:0] rnd();
        logic [31:0] t;
        t = $random(seed);
        return t[7:0];
    endfunction

    // The straps form a binary subaddress, high strap as bit 1.
    function automatic logic hit(input logic [1:0] s);
        return s === {hhi, hlo};
    endfunction

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s exp %h got %h", what, e, g);
        end
    endtask

    task automatic put(input logic [7:0] b, input logic e);
        logic a;
        logic c;
        m.send_byte(b, a, c);
        chk("ack", {7'h0, e}, {7'h0, a});
        chk("sda_quiet", 8'h1, {7'h0, c});
    endtask

    task automatic cmd(input logic [7:0] b);
        put(b, 1'b1);
        chk("cmd_cnt", 8'h1, 8'(cq.size()));
        chk("cmd_data", b, (cq.size() > 0) ? cq.pop_front() : ~b);
    endtask

    // Store and ack only on a subaddress match; pointer moves anyway.
    task automatic disp(input logic [7:0] b);
        logic h;
        h = hit(sub);
        if (h) begin
            exp_ram[ptr] = b;
            wr_m[ptr] = 1'b1;
        end
        put(b, h);
        ptr = (ptr == RAM_DEPTH - 1) ? 0 : ptr + 1;
        if (ptr == 0) begin
            sub = sub + 2'h1;
        end
    endtask

    task automatic load(input int p, input logic [1:0] s);
        @(posedge clk_i);
        #1 {pld, sld, pval, sval} = {2'b11, 6'(p), s};
        @(posedge clk_i);
        #1 {pld, sld} = 2'b00;
        ptr = p;
        sub = s;
    endtask

    // Straps change only while the bus is idle and get time to settle.
    task automatic straps(input logic a, input logic [1:0] s);
        @(posedge clk_i);
        #1 {sa, hhi, hlo} = {a, s};
        repeat (4) @(posedge clk_i);
    endtask

    task automatic rdchk(input int a);
        @(posedge clk_i);
        #1 rda = 6'(a);
        repeat (2) @(posedge clk_i);
        #1 chk("ram", exp_ram[a], rdd);
    endtask

    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h532c_3c33;
        {rst_b_i, sa, hlo, hhi, pld, sld, pval, sval, rda} = '0;
        {ptr, sub, n_errors, n_checks} = '0;
        repeat (8) @(posedge clk_i);
        #1 rst_b_i = 1'b1;
        repeat (4) @(posedge clk_i);
        chk("idle_oe_b", 8'h1, {7'h0, oe_b});
        // Command bytes only, control ignoring its low six bits.
        m.start_cond();
        put(8'h70, 1'b1);
        put(rnd() & 8'h3f, 1'b1);
        repeat (3) cmd(rnd());
        m.stop_cond();
        // Interleaved control, display and command bytes.
        load(rnd() % RAM_DEPTH, 2'h0);
        m.start_cond();
        put(8'h70, 1'b1);
        put(8'hc0 | (rnd() & 8'h3f), 1'b1);
        disp(rnd());
        put(8'h80 | (rnd() & 8'h3f), 1'b1);
        cmd(rnd());
        put(8'h40, 1'b1);
        repeat (4) disp(rnd());
        m.start_cond();
        put(8'h70, 1'b1);
        put(8'h00, 1'b1);
        cmd(8'hc0);
        m.stop_cond();
        // Foreign, read and strap-mismatch addresses stay silent.
        for (int i = 0; i < 5; i++) begin
            m.start_cond();
            put(BAD[i], 1'b0);
            put(8'h00, 1'b0);
            put(rnd(), 1'b0);
            m.stop_cond();
        end
        chk("cmd_cnt", 8'h0, 8'(cq.size()));
        m.start_cond();
        put(8'h72, 1'b0);
        m.start_cond();
        put(8'h70, 1'b1);
        put(8'h00, 1'b1);
        cmd(rnd());
        m.stop_cond();
        // Pointer wrap bumps the subaddress, so later bytes are refused.
        load(38, 2'h0);
        m.start_cond();
        put(8'h70, 1'b1);
        put(8'h40, 1'b1);
        repeat (4) disp(rnd());
        m.stop_cond();
        // Every subaddress strap value, other address select level.
        for (int s = 0; s < 4; s++) begin
            straps(1'b1, 2'(s));
            load(rnd() % RAM_DEPTH, 2'(s + 1));
            m.start_cond();
            put(8'h70, 1'b0);
            m.start_cond();
            put(8'h72, 1'b1);
            put(8'h40, 1'b1);
            disp(rnd());
            m.stop_cond();
            load(rnd() % RAM_DEPTH, 2'(s));
            m.start_cond();
            put(8'h72, 1'b1);
            put(8'h40, 1'b1);
            repeat (2) disp(rnd());
            m.stop_cond();
        end
        for (int i = 0; i < RAM_DEPTH; i++) begin
            if (wr_m[i]) begin
                rdchk(i);
            end
        end
        wrap_up();
    end

    // A hang is cut short at about four times the 0.1 ms of traffic,
    // which keeps a stuck run well under the cycle budget.
    initial begin
        #400_000;
        n_errors++;
        wrap_up();
    end

endmodule
